/* File: serial_status_pkg.sv */
// Function
// - moving the holding character into the shift register sets transmit-empty.
// - transmit-enable low forces transmit-empty to one.
// - a flag clears only on a zero write after reading it as one.
// - writing one to a status flag does nothing.
// - an error-free character moved into receive data sets receive-full.
// - a character completing while receive-full is set raises overrun.
// - asynchronous mode, stop bit sampled zero sets the framing-error flag.
// - framing-error carries no meaning in clocked-synchronous mode.
// - asynchronous with parity, mismatch against selected odd/even sets parity-error.
// - parity-error is meaningless in synchronous mode or without parity.
// - status bits two to zero ignore writes and read as one.
// - status register becomes 0x87 at reset and on standby entry.
// - eight-bit divisor is read/write and with prescaler sets baud rate.
// - divisor loads 0xFF, the slowest rate, at reset and standby.
// - prescaler codes 0..3 divide the clock by 1, 4, 16, 64.
// - asynchronous bit rate is clock over 64 times 4^n times (N+1).
// - synchronous bit rate is clock over 8 times 4^n times (N+1).
// - with receive interrupts on, overrun, framing or parity error requests interrupt.
`default_nettype none
package serial_status_pkg;
    localparam logic [15:0] ADDR_BIT_RATE_DIVISOR = 16'hFFD9;
    localparam logic [15:0] ADDR_SERIAL_STATUS = 16'hFFDC;
    localparam logic [15:0] ADDR_LINK_CONFIG = 16'hFFDD;
    localparam logic [7:0] STATUS_RESET = 8'h87;
    localparam logic [7:0] DIVISOR_RESET = 8'hFF;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    localparam logic [2:0] STATUS_RESERVED_ONES = 3'h7;
    // flag positions inside the status byte
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_RX_FULL = 6;
    localparam int BIT_OVERRUN = 5;
    localparam int BIT_FRAMING = 4;
    localparam int BIT_PARITY = 3;
    localparam int FLAG_COUNT = 5;
    localparam int FLAG_LOW_BIT = 3;
    // link configuration register fields
    localparam int CFG_SYNC_MODE = 7;
    localparam int CFG_RX_IRQ_ENABLE = 6;
    localparam int CFG_PARITY_ENABLE = 5;
    localparam int CFG_ODD_PARITY = 4;
    localparam int CFG_TX_ENABLE = 2;
    localparam int CFG_PRESCALE_HIGH = 1;
    localparam int CFG_PRESCALE_LOW = 0;
    // prescaler terminal counts for codes 0..3 (divide by 1, 4, 16, 64)
    localparam logic [5:0] PRESCALE_LAST_0 = 6'h00;
    localparam logic [5:0] PRESCALE_LAST_1 = 6'h03;
    localparam logic [5:0] PRESCALE_LAST_2 = 6'h0F;
    localparam logic [5:0] PRESCALE_LAST_3 = 6'h3F;
    // bit-time stage: 64 rate ticks async, 8 sync
    localparam logic [5:0] ASYNC_BIT_LAST = 6'h3F;
    localparam logic [5:0] SYNC_BIT_LAST = 6'h07;
endpackage
`default_nettype wire

/* File: bit_rate_generator.sv */
`timescale 1ns/1ps
`default_nettype none
module bit_rate_generator
    import serial_status_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic restart,
    // settings
    input wire logic [DIV_WIDTH-1:0] divisor,
    input wire logic [1:0] prescaler_select,
    input wire logic sync_mode,
    // ticks
    output logic rate_tick,
    output logic bit_tick
);
    logic [5:0] prescale_reg;
    logic [5:0] prescale_last;
    logic [DIV_WIDTH-1:0] divide_reg;
    logic [5:0] bit_reg;
    logic [5:0] bit_last;
    logic prescale_tick;
    logic divide_end;

    always_comb begin
        case (prescaler_select)
            2'h0: prescale_last = PRESCALE_LAST_0;
            2'h1: prescale_last = PRESCALE_LAST_1;
            2'h2: prescale_last = PRESCALE_LAST_2;
            default: prescale_last = PRESCALE_LAST_3;
        endcase
    end

    assign bit_last = sync_mode ? SYNC_BIT_LAST : ASYNC_BIT_LAST;
    assign prescale_tick = (prescale_reg >= prescale_last);
    // compare with >= so a smaller setting written mid-count never wraps the whole range
    assign divide_end = prescale_tick && (divide_reg >= divisor);

    always_ff @(posedge clock) begin
        if (!rstn || restart) begin
            prescale_reg <= '0;
        end else if (prescale_tick) begin
            prescale_reg <= '0;
        end else begin
            prescale_reg <= prescale_reg + 6'h01;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || restart) begin
            divide_reg <= '0;
        end else if (divide_end) begin
            divide_reg <= '0;
        end else if (prescale_tick) begin
            divide_reg <= divide_reg + DIV_WIDTH'(1);
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || restart) begin
            bit_reg <= '0;
            rate_tick <= 1'b0;
            bit_tick <= 1'b0;
        end else begin
            rate_tick <= divide_end;
            bit_tick <= divide_end && (bit_reg >= bit_last);
            if (divide_end) begin
                bit_reg <= (bit_reg >= bit_last) ? 6'h00 : bit_reg + 6'h01;
            end
        end
    end
endmodule // bit_rate_generator
`default_nettype wire

/* File: serial_status_bit_rate.sv */
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module serial_status_bit_rate
    import serial_status_pkg::*;
#(
    parameter int DIV_WIDTH = 8
) (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic standby,
    // register port
    input wire logic [15:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // transmit datapath events
    input wire logic tx_transfer,
    // receive datapath events
    input wire logic rx_done,
    input wire logic rx_stop_bit,
    input wire logic rx_parity_bit,
    input wire logic rx_data_parity,
    // status to datapath
    output logic transmit_empty_flag,
    output logic receive_full_flag,
    output logic rx_load_data,
    output logic transmit_enable_bit,
    output logic sync_mode,
    output logic parity_enable,
    output logic odd_parity,
    // interrupt request
    output logic receive_error_interrupt,
    // rate ticks
    output logic rate_tick,
    output logic bit_tick
);
    logic [DIV_WIDTH-1:0] divisor_reg;
    logic [7:0] config_reg;
    logic [FLAG_COUNT-1:0] flags_reg;
    logic [FLAG_COUNT-1:0] armed_reg;
    logic [FLAG_COUNT-1:0] flag_set;
    logic [FLAG_COUNT-1:0] flag_clear;
    logic [7:0] status_value;
    logic [7:0] rdata_next;
    logic init;
    logic sel_divisor;
    logic sel_status;
    logic sel_config;
    logic tx_enable_now;
    logic async_mode;
    logic framing_event;
    logic parity_event;
    logic overrun_event;
    logic good_char_event;
    logic parity_mismatch;
    logic error_pending;

    // standby re-initialises exactly like reset
    assign init = !rstn || standby;

    assign sel_divisor = (addr == ADDR_BIT_RATE_DIVISOR);
    assign sel_status = (addr == ADDR_SERIAL_STATUS);
    assign sel_config = (addr == ADDR_LINK_CONFIG);

    assign tx_enable_now = config_reg[CFG_TX_ENABLE];
    assign async_mode = !config_reg[CFG_SYNC_MODE];

    // receive event classification
    assign parity_mismatch = ((rx_data_parity ^ rx_parity_bit) != config_reg[CFG_ODD_PARITY]);
    // framing is only judged in asynchronous mode
    assign framing_event = rx_done && async_mode && !rx_stop_bit;
    // parity only judged when the format carries a parity bit
    assign parity_event = rx_done && async_mode && config_reg[CFG_PARITY_ENABLE] && parity_mismatch;
    // the unread character is kept; the new one is dropped
    assign overrun_event = rx_done && flags_reg[BIT_RX_FULL - FLAG_LOW_BIT];
    assign good_char_event = rx_done && !framing_event && !parity_event && !overrun_event;

    // hardware set sources per flag
    always_comb begin
        flag_set = '0;
        flag_set[BIT_TX_EMPTY - FLAG_LOW_BIT] = tx_transfer || !tx_enable_now;
        flag_set[BIT_RX_FULL - FLAG_LOW_BIT] = good_char_event;
        flag_set[BIT_OVERRUN - FLAG_LOW_BIT] = overrun_event;
        flag_set[BIT_FRAMING - FLAG_LOW_BIT] = framing_event;
        flag_set[BIT_PARITY - FLAG_LOW_BIT] = parity_event;
    end

    // one read-then-clear slice per flag
    genvar i;
    generate
        for (i = 0; i < FLAG_COUNT; i++) begin : g_flag
            // a zero write clears only after the flag was seen as one
            assign flag_clear[i] = wr && sel_status && !wdata[FLAG_LOW_BIT + i] && armed_reg[i];

            always_ff @(posedge clock) begin
                if (init) begin
                    flags_reg[i] <= STATUS_RESET[FLAG_LOW_BIT + i];
                end else if (flag_set[i]) begin
                    // set beats a same-cycle clear so no event is lost
                    flags_reg[i] <= 1'b1;
                end else if (flag_clear[i]) begin
                    flags_reg[i] <= 1'b0;
                end
                // writing one leaves the flag alone
            end

            always_ff @(posedge clock) begin
                if (init) begin
                    armed_reg[i] <= 1'b0;
                end else if (wr && sel_status) begin
                    // any status write consumes the read; a fresh read is needed next time
                    armed_reg[i] <= 1'b0;
                end else if (rd && sel_status && flags_reg[i]) begin
                    armed_reg[i] <= 1'b1;
                end else if (!flags_reg[i]) begin
                    armed_reg[i] <= 1'b0;
                end
            end
        end
    endgenerate

    // reserved low bits are constant ones
    assign status_value = {flags_reg, STATUS_RESERVED_ONES};

    // divisor register
    always_ff @(posedge clock) begin
        if (init) begin
            divisor_reg <= DIVISOR_RESET[DIV_WIDTH-1:0];
        end else if (wr && sel_divisor) begin
            divisor_reg <= wdata[DIV_WIDTH-1:0];
        end
    end

    // link configuration register
    always_ff @(posedge clock) begin
        if (init) begin
            config_reg <= CONFIG_RESET;
        end else if (wr && sel_config) begin
            config_reg <= wdata;
        end
    end

    // read mux, unmapped addresses answer zero
    always_comb begin
        rdata_next = READ_UNMAPPED;
        if (sel_divisor) begin
            rdata_next = '0;
            rdata_next[DIV_WIDTH-1:0] = divisor_reg;
        end else if (sel_status) begin
            rdata_next = status_value;
        end else if (sel_config) begin
            rdata_next = config_reg;
        end
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clock) begin
        if (init) begin
            rdata <= READ_UNMAPPED;
        end else if (rd) begin
            rdata <= rdata_next;
        end else begin
            rdata <= READ_UNMAPPED;
        end
    end

    // error level from the sticky flags
    assign error_pending = flags_reg[BIT_OVERRUN - FLAG_LOW_BIT]
        || flags_reg[BIT_FRAMING - FLAG_LOW_BIT]
        || flags_reg[BIT_PARITY - FLAG_LOW_BIT];

    always_ff @(posedge clock) begin
        if (init) begin
            receive_error_interrupt <= 1'b0;
        end else begin
            receive_error_interrupt <= config_reg[CFG_RX_IRQ_ENABLE] && error_pending;
        end
    end

    // status and settings toward the datapath
    always_ff @(posedge clock) begin
        if (init) begin
            transmit_empty_flag <= STATUS_RESET[BIT_TX_EMPTY];
            receive_full_flag <= STATUS_RESET[BIT_RX_FULL];
        end else begin
            // the holding register may only be reloaded by software while this reads one
            transmit_empty_flag <= flags_reg[BIT_TX_EMPTY - FLAG_LOW_BIT];
            receive_full_flag <= flags_reg[BIT_RX_FULL - FLAG_LOW_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (init) begin
            rx_load_data <= 1'b0;
        end else begin
            rx_load_data <= good_char_event;
        end
    end

    always_ff @(posedge clock) begin
        if (init) begin
            transmit_enable_bit <= CONFIG_RESET[CFG_TX_ENABLE];
            sync_mode <= CONFIG_RESET[CFG_SYNC_MODE];
            parity_enable <= CONFIG_RESET[CFG_PARITY_ENABLE];
            odd_parity <= CONFIG_RESET[CFG_ODD_PARITY];
        end else begin
            transmit_enable_bit <= config_reg[CFG_TX_ENABLE];
            sync_mode <= config_reg[CFG_SYNC_MODE];
            parity_enable <= config_reg[CFG_PARITY_ENABLE];
            odd_parity <= config_reg[CFG_ODD_PARITY];
        end
    end

    // rate generation; a new divisor is compared at once and governs the count already running
    bit_rate_generator #(
        .DIV_WIDTH(DIV_WIDTH)
    ) u_rate (
        .clock(clock),
        .rstn(rstn),
        .restart(standby),
        .divisor(divisor_reg),
        .prescaler_select({config_reg[CFG_PRESCALE_HIGH], config_reg[CFG_PRESCALE_LOW]}),
        .sync_mode(config_reg[CFG_SYNC_MODE]),
        .rate_tick(rate_tick),
        .bit_tick(bit_tick)
    );
endmodule // serial_status_bit_rate
`default_nettype wire

/* File: serial_status_bit_rate_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_status_bit_rate_sva
    import serial_status_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    input wire logic standby,
    // register port
    input wire logic [15:0] addr,
    input wire logic wr,
    input wire logic rd,
    input wire logic [7:0] rdata,
    // datapath
    input wire logic tx_transfer,
    input wire logic rx_done,
    input wire logic transmit_empty_flag,
    input wire logic receive_full_flag,
    input wire logic rx_load_data,
    input wire logic transmit_enable_bit,
    input wire logic receive_error_interrupt
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn || standby);
    logic mapped;
    assign mapped = addr == ADDR_BIT_RATE_DIVISOR || addr == ADDR_SERIAL_STATUS || addr == ADDR_LINK_CONFIG;
    te_forces_empty_a: assert property (!transmit_enable_bit ##1 !transmit_enable_bit |-> transmit_empty_flag)
        else $error("transmit empty low while transmit disabled");
    // copies lag one cycle, so the cause sits two samples back
    empty_set_cause_a: assert property ($rose(transmit_empty_flag) |->
        $past(tx_transfer, 2) || !transmit_enable_bit || !$past(transmit_enable_bit))
        else $error("transmit empty rose without a cause");
    load_sets_full_a: assert property (rx_load_data |-> $past(rx_done) ##1 receive_full_flag)
        else $error("load pulse not followed by receive full");
    no_load_overrun_a: assert property (rx_load_data |-> !receive_full_flag)
        else $error("character loaded while receive full");
    full_clear_wr_a: assert property ($fell(receive_full_flag) |->
        $past(wr, 2) && $past(addr, 2) == ADDR_SERIAL_STATUS)
        else $error("receive full cleared without a status write");
    reserved_ones_a: assert property (rd && addr == ADDR_SERIAL_STATUS |=> rdata[2:0] == STATUS_RESERVED_ONES)
        else $error("reserved status bits not one");
    unmapped_zero_a: assert property (rd && !mapped |=> rdata == READ_UNMAPPED)
        else $error("unmapped read not zero");
    irq_cause_a: assert property ($rose(receive_error_interrupt) |-> $past(rx_done, 2) || $past(wr, 2))
        else $error("error request rose without a cause");
    cover property (rx_load_data);
    cover property ($rose(receive_error_interrupt));
    cover property ($fell(transmit_empty_flag));
endmodule // serial_status_bit_rate_sva
bind serial_status_bit_rate serial_status_bit_rate_sva u_serial_status_bit_rate_sva (
    .clock(clock), .rstn(rstn), .standby(standby), .addr(addr), .wr(wr), .rd(rd), .rdata(rdata),
    .tx_transfer(tx_transfer), .rx_done(rx_done), .transmit_empty_flag(transmit_empty_flag),
    .receive_full_flag(receive_full_flag), .rx_load_data(rx_load_data),
    .transmit_enable_bit(transmit_enable_bit), .receive_error_interrupt(receive_error_interrupt));
`default_nettype wire

/* File: serial_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_link_model (
    // clock
    input wire logic clock,
    // commands
    input wire logic rx_go,
    input wire logic [2:0] rx_bits,
    // receive events
    output logic rx_done,
    output logic rx_stop_bit,
    output logic rx_parity_bit,
    output logic rx_data_parity
);
    logic idle_reg = 1'b0;
    // lines outside a character wander, so stale values never match by luck
    always @(posedge clock) begin
        idle_reg <= ~idle_reg;
    end
    assign rx_done = rx_go;
    assign rx_stop_bit = rx_go ? rx_bits[2] : idle_reg;
    assign rx_parity_bit = rx_go ? rx_bits[1] : ~idle_reg;
    assign rx_data_parity = rx_go ? rx_bits[0] : idle_reg;
endmodule // serial_link_model
`default_nettype wire

/* File: serial_status_bit_rate_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_status_bit_rate_tb_top
    import serial_status_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic standby = 1'b0;
    logic [15:0] addr = 16'h0000;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic tx_transfer = 1'b0;
    logic rx_go = 1'b0;
    logic [2:0] rx_bits = 3'h0;
    logic [7:0] rdata, st, arm, cfg, got;
    logic rx_done, rx_stop_bit, rx_parity_bit, rx_data_parity;
    logic transmit_empty_flag, receive_full_flag, receive_error_interrupt, rate_tick, bit_tick;
    logic rx_load_data, transmit_enable_bit, sync_mode, parity_enable, odd_parity;
    int num_errors = 0;
    int compares = 0;
    int seed = 32'h0000_9b90;
    always #2 clock = ~clock;
    serial_status_bit_rate u_serial_status_bit_rate (.clock(clock), .rstn(rstn), .standby(standby),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .tx_transfer(tx_transfer),
        .rx_done(rx_done), .rx_stop_bit(rx_stop_bit), .rx_parity_bit(rx_parity_bit),
        .rx_data_parity(rx_data_parity), .transmit_empty_flag(transmit_empty_flag),
        .receive_full_flag(receive_full_flag), .rx_load_data(rx_load_data),
        .transmit_enable_bit(transmit_enable_bit), .sync_mode(sync_mode), .parity_enable(parity_enable),
        .odd_parity(odd_parity), .receive_error_interrupt(receive_error_interrupt),
        .rate_tick(rate_tick), .bit_tick(bit_tick));
    serial_link_model u_serial_link_model (.clock(clock), .rx_go(rx_go), .rx_bits(rx_bits),
        .rx_done(rx_done), .rx_stop_bit(rx_stop_bit), .rx_parity_bit(rx_parity_bit),
        .rx_data_parity(rx_data_parity));
    // b: stop bit, parity bit, data parity
    function automatic logic [7:0] rx_next(input logic [7:0] s, input logic [7:0] c, input logic [2:0] b);
        logic fe;
        logic pe;
        fe = !c[7] && !b[2];
        pe = !c[7] && c[5] && ((b[0] ^ b[1]) != c[4]);
        if (s[6]) s[5] = 1'b1;
        else if (!fe && !pe) s[6] = 1'b1;
        s[4] = s[4] | fe;
        s[3] = s[3] | pe;
        return s;
    endfunction
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] val);
        compares++;
        if (val !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, val);
        end
    endtask
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clock);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string nm);
        @(posedge clock);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock);
        rd <= 1'b0;
        #1;
        chk(nm, exp, rdata);
    endtask
    task automatic per(input logic sel, input int exp);
        int cnt;
        int seen;
        int last;
        cnt = 0;
        seen = 0;
        last = -1;
        for (int k = 0; k < 20000 && seen < 3; k++) begin
            @(posedge clock);
            #1;
            cnt++;
            if ((sel ? bit_tick : rate_tick) === 1'b1) begin
                if (seen > 0) last = cnt;
                seen++;
                cnt = 0;
            end
        end
        compares++;
        if (last != exp) begin
            num_errors++;
            $display("wrong value tick period expected %0d seen %0d", exp, last);
        end
    endtask
    task automatic stop_test;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        st = 8'h87;
        arm = 8'h00;
        cfg = 8'h00;
        rd_chk(ADDR_SERIAL_STATUS, 8'h87, "status");
        rd_chk(ADDR_BIT_RATE_DIVISOR, 8'hff, "divisor");
        rd_chk(16'hffda, 8'h00, "unmapped");
        wr_reg(ADDR_SERIAL_STATUS, 8'hff);
        for (int i = 0; i < 400; i++) begin
            got = 8'($random(seed));
            case ($unsigned($random(seed)) % 6)
                0: begin
                    @(posedge clock);
                    rx_go <= 1'b1;
                    rx_bits <= got[2:0];
                    @(posedge clock);
                    rx_go <= 1'b0;
                    // load pulse stands only in this cycle
                    got[7] = !st[6];
                    st = rx_next(st, cfg, got[2:0]);
                    #1;
                    chk("load", {7'h00, got[7] & st[6]}, {7'h00, rx_load_data});
                end
                1, 2: begin
                    rd_chk(ADDR_SERIAL_STATUS, st, "status");
                    arm = st & 8'hf8;
                    chk("outputs", {5'h00, st[7:6], cfg[6] & |st[5:3]},
                        {5'h00, transmit_empty_flag, receive_full_flag, receive_error_interrupt});
                end
                3: begin
                    wr_reg(ADDR_SERIAL_STATUS, got);
                    st = (st & ~(arm & ~got)) | {~cfg[2], 7'h00};
                    arm = 8'h00;
                end
                4: begin
                    // a character waits only after software wrote it and cleared the empty flag
                    if (!st[7]) begin
                        @(posedge clock);
                        tx_transfer <= 1'b1;
                        @(posedge clock);
                        tx_transfer <= 1'b0;
                        st[7] = 1'b1;
                    end
                end
                default: begin
                    wr_reg(ADDR_LINK_CONFIG, got);
                    cfg = got;
                    st[7] = st[7] | ~cfg[2];
                    rd_chk(ADDR_LINK_CONFIG, cfg, "config");
                    chk("copies", {4'h0, cfg[7], cfg[5:4], cfg[2]},
                        {4'h0, sync_mode, parity_enable, odd_parity, transmit_enable_bit});
                end
            endcase
        end
        // divisor 2 keeps the slowest prescaler within a short run
        for (int n = 0; n < 4; n++) begin
            wr_reg(ADDR_LINK_CONFIG, {6'h00, n[1:0]});
            wr_reg(ADDR_BIT_RATE_DIVISOR, 8'h02);
            per(1'b0, 3 << (2 * n));
        end
        wr_reg(ADDR_BIT_RATE_DIVISOR, got);
        rd_chk(ADDR_BIT_RATE_DIVISOR, got, "divisor");
        wr_reg(ADDR_BIT_RATE_DIVISOR, 8'h01);
        wr_reg(ADDR_LINK_CONFIG, 8'h00);
        per(1'b1, 128);
        wr_reg(ADDR_LINK_CONFIG, 8'h80);
        per(1'b1, 16);
        @(posedge clock);
        standby <= 1'b1;
        repeat (2) @(posedge clock);
        standby <= 1'b0;
        rd_chk(ADDR_SERIAL_STATUS, 8'h87, "standby status");
        rd_chk(ADDR_BIT_RATE_DIVISOR, 8'hff, "standby divisor");
        stop_test();
    end
endmodule // serial_status_bit_rate_tb_top
`default_nettype wire
